// ---- buck_seq_pkg.sv ----
// shared constants of the buck mode and fault sequencer
package buck_seq_pkg;
  // clock rate and timing figures in their own units
  localparam int CLK_MHZ   = 100;
  localparam int RAMP_US   = 1000;
  localparam int HICCUP_US = 128;
  localparam int DELAY_US  = 250;
  localparam int CONV_US   = 10;
  // derived cycle counts
  localparam int RAMP_CYCLES   = RAMP_US * CLK_MHZ;
  localparam int HICCUP_CYCLES = HICCUP_US * CLK_MHZ;
  localparam int DELAY_CYCLES  = DELAY_US * CLK_MHZ;
  localparam int CONV_CYCLES   = CONV_US * CLK_MHZ;
  // reference moves one code per step; 256 steps span the soft start
  localparam int STEP_DIV      = 256;
  localparam int TW            = 17;
  localparam logic [5:0] TRIP_LIMIT = 6'h20;
  // startup code is (LEVEL_BASE + level) shifted by factor; lsb 12.5 mV
  localparam logic [4:0] LEVEL_BASE = 5'h08;
  localparam logic [1:0] FACTOR_HALF = 2'h0;
  localparam logic [1:0] FACTOR_ONE  = 2'h1;
  localparam logic [1:0] FACTOR_TWO  = 2'h2;
  // reset values of the control bits
  localparam logic FORCED_FIXED_FREQUENCY_MODE_RESET      = 1'h0;
  localparam logic HICCUP_RESET    = 1'h1;
  localparam logic SW_EN_RESET     = 1'h1;
  localparam logic DISCHARGE_RESET = 1'h1;
  localparam logic [7:0] SETPOINT_RESET = 8'h00;
  // bus address per resistor level, lowest resistor first
  localparam logic [6:0] ADDR_TABLE [16] = '{
    7'h47, 7'h40, 7'h4F, 7'h4E, 7'h4D, 7'h4C, 7'h4B, 7'h4A,
    7'h49, 7'h48, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46};
  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_RAMP, ST_RUN, ST_HICCUP, ST_LATCHED, ST_PAUSE
  } seq_state_t;
endpackage

// ---- buck_mode_fault_sequencer.sv ----
// control sequencer of a step-down converter: modes, start-up, faults
`timescale 1ns/1ps
// What this block does
// - near-dropout input forbids light-load pulse mode
// - forced fixed-frequency bit forbids pulse mode
// - enable delay before switching and bus access
// - soft start ramps output over 1 ms
// - ramp starts from pre-biased output level
// - high-side limit: high off, low on
// - 32 trips: stop, wait 128 us, restart
// - no auto-retry: 32 trips latch off
// - lockout stops, discharges, keeps registers, restarts
// - lockout flag set below falling threshold
// - supply below 1.8 V resets all registers
// - thermal warning flag, operation continues
// - thermal shutdown stops, discharges, restarts later
// - enable low: off, registers reset but discharge
// - enable low refuses register reads and writes
// - software enable toggle restarts soft start only
// - discharge in shutdown, lockout, thermal, if enabled
// - discharge bit defaults on enable rising edge
// - setpoint write in ramp: startup first
// - resistor level gives startup code and address
// - fixed voltage factor scales startup code
// - resistor current source off after conversion
module buck_mode_fault_sequencer #(
  parameter int DELAY_CYC  = buck_seq_pkg::DELAY_CYCLES,
  parameter int RAMP_CYC   = buck_seq_pkg::RAMP_CYCLES,
  parameter int HICCUP_CYC = buck_seq_pkg::HICCUP_CYCLES,
  parameter logic [1:0] FACTOR_SEL = buck_seq_pkg::FACTOR_ONE
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       enable_pin,
  input  wire logic       vin_lockout,
  input  wire logic       vin_near_vout,
  input  wire logic       light_load,
  input  wire logic       hs_limit,
  input  wire logic       ls_limit,
  input  wire logic       thermal_warning_level,
  input  wire logic       thermal_shutdown_level,
  input  wire logic       thermal_release,
  input  wire logic       pwm_on_request,
  input  wire logic [7:0] output_sense_pin,
  input  wire logic [3:0] setpoint_select_pin,
  input  wire logic       ctrl_wr,
  input  wire logic       wr_sw_enable,
  input  wire logic       wr_forced_fixed_frequency_mode,
  input  wire logic       wr_hiccup,
  input  wire logic       wr_discharge,
  input  wire logic       setpoint_wr,
  input  wire logic [7:0] setpoint_data,
  input  wire logic       status_clear,
  output logic            hs_gate,
  output logic            ls_gate,
  output logic            light_load_pulse_mode,
  output logic            forced_fixed_frequency_mode,
  output logic            hiccup_enable,
  output logic            sw_enable,
  output logic            discharge_enable,
  output logic            discharge_on,
  output logic            resistor_code_decoder_on,
  output logic            bus_access_ok,
  output logic            switching,
  output logic [7:0]      vout_ref,
  output logic [7:0]      startup_code,
  output logic [6:0]      target_address,
  output logic [7:0]      setpoint,
  output logic            low_input_lockout,
  output logic            warning_flag
);
  localparam int NSYNC = 22;
  localparam int STEP_CYC = RAMP_CYC / buck_seq_pkg::STEP_DIV;
  localparam logic [buck_seq_pkg::TW-1:0] CONV_LAST =
    buck_seq_pkg::TW'(buck_seq_pkg::CONV_CYCLES - 1);

  logic [NSYNC-1:0] pin_meta, pin_sync;
  logic en_s, low_input_lockout_s, near_s, light_s, hs_s, ls_s, tw_s, tsd_s, rel_s, pwm_s;
  logic [7:0] sense_s;
  logic [3:0] level_s;
  logic en_d, hs_d, en_rise, hs_rise;

  // two-stage synchronisers; only pin_sync is read by logic
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      en_d     <= 1'b0;
      hs_d     <= 1'b0;
    end else begin
      pin_meta <= {enable_pin, vin_lockout, vin_near_vout, light_load, hs_limit,
                   ls_limit, thermal_warning_level, thermal_shutdown_level,
                   thermal_release, pwm_on_request, output_sense_pin,
                   setpoint_select_pin};
      pin_sync <= pin_meta;
      en_d     <= en_s;
      hs_d     <= hs_s;
    end
  end
  assign {en_s, low_input_lockout_s, near_s, light_s, hs_s, ls_s, tw_s, tsd_s, rel_s, pwm_s,
          sense_s, level_s} = pin_sync;
  assign en_rise = en_s & ~en_d;
  assign hs_rise = hs_s & ~hs_d;

  buck_seq_pkg::seq_state_t state, next_state;
  logic [buck_seq_pkg::TW-1:0] timer, next_timer, step, next_step, conv, next_conv;
  logic [5:0] trips, next_trips;
  logic [7:0] next_vout_ref, next_startup_code, next_setpoint, tgt;
  logic [6:0] next_target_address;
  logic next_r2d, next_tsd, tsd, in_limit, next_limit, go_run, stop_req, wr_ok;
  logic next_forced_fixed_frequency_mode, next_hiccup, next_sw, next_dis, next_lock, next_warn;
  logic next_hs, next_ls, next_psm, next_dchg;

  // register file; shutdown by pin resets all but the discharge bit
  always_comb begin
    wr_ok         = ctrl_wr & bus_access_ok;
    next_forced_fixed_frequency_mode     = forced_fixed_frequency_mode;
    next_hiccup   = hiccup_enable;
    next_sw       = sw_enable;
    next_dis      = discharge_enable;
    next_setpoint = setpoint;
    // lockout flag, set wins over clear
    next_lock     = (low_input_lockout & ~status_clear) | low_input_lockout_s;
    // warning flag only, no effect on switching
    next_warn     = (warning_flag & ~status_clear) | tw_s;
    if (en_rise) begin
      next_dis = buck_seq_pkg::DISCHARGE_RESET;
    end else if (wr_ok) begin
      next_dis = wr_discharge;
    end
    if (wr_ok) begin
      next_forced_fixed_frequency_mode   = wr_forced_fixed_frequency_mode;
      next_hiccup = wr_hiccup;
      next_sw     = wr_sw_enable;
    end
    // new setpoint is held until ramp reaches startup
    if (setpoint_wr && bus_access_ok) begin
      next_setpoint = setpoint_data;
    end else if (state == buck_seq_pkg::ST_DELAY && conv == CONV_LAST) begin
      next_setpoint = next_startup_code;
    end
    // pin low resets registers, discharge bit kept
    if (!en_s) begin
      next_forced_fixed_frequency_mode     = buck_seq_pkg::FORCED_FIXED_FREQUENCY_MODE_RESET;
      next_hiccup   = buck_seq_pkg::HICCUP_RESET;
      next_sw       = buck_seq_pkg::SW_EN_RESET;
      next_setpoint = buck_seq_pkg::SETPOINT_RESET;
      next_lock     = 1'b0;
      next_warn     = 1'b0;
    end
  end

  // async reset stands for supply below 1.8 V
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      forced_fixed_frequency_mode <= buck_seq_pkg::FORCED_FIXED_FREQUENCY_MODE_RESET;
      hiccup_enable     <= buck_seq_pkg::HICCUP_RESET;
      sw_enable         <= buck_seq_pkg::SW_EN_RESET;
      discharge_enable  <= buck_seq_pkg::DISCHARGE_RESET;
      setpoint          <= buck_seq_pkg::SETPOINT_RESET;
      low_input_lockout <= 1'b0;
      warning_flag      <= 1'b0;
    end else begin
      forced_fixed_frequency_mode <= next_forced_fixed_frequency_mode;
      hiccup_enable     <= next_hiccup;
      sw_enable         <= next_sw;
      discharge_enable  <= next_dis;
      setpoint          <= next_setpoint;
      low_input_lockout <= next_lock;
      warning_flag      <= next_warn;
    end
  end

  // bus open only after the enable delay
  assign bus_access_ok = en_s && state != buck_seq_pkg::ST_OFF
                         && state != buck_seq_pkg::ST_DELAY;
  assign switching = state == buck_seq_pkg::ST_RAMP || state == buck_seq_pkg::ST_RUN;

  // sequencer: start-up, soft start, overload and shutdown handling
  always_comb begin
    next_state          = state;
    next_timer          = timer;
    next_step           = step;
    next_conv           = conv;
    next_trips          = trips;
    next_vout_ref       = vout_ref;
    next_r2d            = resistor_code_decoder_on;
    next_startup_code   = startup_code;
    next_target_address = target_address;
    // shutdown held until temperature 20 C lower
    next_tsd = (tsd & ~rel_s) | tsd_s;
    stop_req = ~next_sw | low_input_lockout_s | next_tsd;
    go_run   = 1'b0;
    // ramp aims at startup code before the setpoint
    tgt = (state == buck_seq_pkg::ST_RAMP) ? startup_code : setpoint;
    unique case (state)
      buck_seq_pkg::ST_OFF: begin
        if (en_s) begin
          next_state = buck_seq_pkg::ST_DELAY;
          next_timer = buck_seq_pkg::TW'(DELAY_CYC - 1);
          next_conv  = '0;
          next_r2d   = 1'b1;
        end
      end
      // enable delay; resistor conversion inside it
      buck_seq_pkg::ST_DELAY: begin
        if (resistor_code_decoder_on) begin
          next_conv = conv + 1'b1;
          if (conv == CONV_LAST) begin
            next_r2d            = 1'b0;
            next_target_address = buck_seq_pkg::ADDR_TABLE[level_s];
            next_startup_code   = 8'({3'h0, buck_seq_pkg::LEVEL_BASE + 5'(level_s)}
                                     << (FACTOR_SEL + 2'h1));
          end
        end
        next_timer = timer - 1'b1;
        go_run     = timer == '0;
      end
      buck_seq_pkg::ST_RAMP, buck_seq_pkg::ST_RUN: begin
        if (hs_rise && trips != buck_seq_pkg::TRIP_LIMIT) begin
          next_trips = trips + 1'b1;
        end
        if (stop_req) begin
          next_state = buck_seq_pkg::ST_PAUSE;
        end else if (trips == buck_seq_pkg::TRIP_LIMIT) begin
          next_state = hiccup_enable ? buck_seq_pkg::ST_HICCUP
                                     : buck_seq_pkg::ST_LATCHED;
          next_timer = buck_seq_pkg::TW'(HICCUP_CYC - 1);
        end else begin
          // soft start lasts the ramp time
          if (state == buck_seq_pkg::ST_RAMP) begin
            next_timer = timer - 1'b1;
            if (timer == '0) begin
              next_state = buck_seq_pkg::ST_RUN;
            end
          end
          next_step = step + 1'b1;
          if (step == buck_seq_pkg::TW'(STEP_CYC - 1)) begin
            next_step = '0;
            if (vout_ref < tgt) begin
              next_vout_ref = vout_ref + 1'b1;
            end else if (vout_ref > tgt) begin
              next_vout_ref = vout_ref - 1'b1;
            end
          end
        end
      end
      buck_seq_pkg::ST_HICCUP: begin
        next_timer = timer - 1'b1;
        if (stop_req) begin
          next_state = buck_seq_pkg::ST_PAUSE;
        end else begin
          go_run = timer == '0;
        end
      end
      // only a control register write or enable low unlatches
      buck_seq_pkg::ST_LATCHED: begin
        go_run = wr_ok;
      end
      // wait for all stop causes to clear
      buck_seq_pkg::ST_PAUSE: begin
        go_run = ~stop_req;
      end
      // unused state code falls back to off
      default: begin
        next_state = buck_seq_pkg::ST_OFF;
      end
    endcase
    if (go_run) begin
      next_state = stop_req ? buck_seq_pkg::ST_PAUSE : buck_seq_pkg::ST_RAMP;
      next_timer = buck_seq_pkg::TW'(RAMP_CYC - 1);
      next_step  = '0;
      next_trips = '0;
      // ramp starts from the sensed pre-bias
      next_vout_ref = sense_s;
    end
    // pin low stops everything; sampled values kept
    if (!en_s) begin
      next_state    = buck_seq_pkg::ST_OFF;
      next_r2d      = 1'b0;
      next_vout_ref = '0;
      next_trips    = '0;
    end
  end

  // power stage drive and mode outputs
  always_comb begin
    // limit holds until low-side limit is reached
    next_limit = switching & ((in_limit & ~ls_s) | hs_s);
    next_hs    = switching & pwm_s & ~next_limit;
    // pulse mode barred near dropout or forced
    next_psm   = switching & light_s & ~next_forced_fixed_frequency_mode & ~near_s;
    next_ls    = switching & (next_limit | (~pwm_s & ~next_psm));
    // discharge when enable low, software off, lockout or thermal shutdown, if the bit allows
    next_dchg  = next_dis & (~en_s | ~next_sw | low_input_lockout_s | next_tsd);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state          <= buck_seq_pkg::ST_OFF;
      timer          <= '0;
      step           <= '0;
      conv           <= '0;
      trips          <= '0;
      vout_ref       <= '0;
      resistor_code_decoder_on <= 1'b0;
      startup_code   <= '0;
      target_address <= '0;
      tsd            <= 1'b0;
      in_limit       <= 1'b0;
      hs_gate        <= 1'b0;
      ls_gate        <= 1'b0;
      light_load_pulse_mode <= 1'b0;
      discharge_on   <= 1'b0;
    end else begin
      state          <= next_state;
      timer          <= next_timer;
      step           <= next_step;
      conv           <= next_conv;
      trips          <= next_trips;
      vout_ref       <= next_vout_ref;
      resistor_code_decoder_on <= next_r2d;
      startup_code   <= next_startup_code;
      target_address <= next_target_address;
      tsd            <= next_tsd;
      in_limit       <= next_limit;
      hs_gate        <= next_hs;
      ls_gate        <= next_ls;
      light_load_pulse_mode <= next_psm;
      discharge_on   <= next_dchg;
    end
  end

  property p_near_dropout;
    @(posedge clk_sys) disable iff (!reset_n) near_s |=> !light_load_pulse_mode;
  endproperty
  a_near_dropout: assert property (p_near_dropout)
    else $error("pulse mode entered near dropout");

  property p_forced;
    @(posedge clk_sys) disable iff (!reset_n)
      forced_fixed_frequency_mode ##1 forced_fixed_frequency_mode |-> !light_load_pulse_mode;
  endproperty
  a_forced: assert property (p_forced)
    else $error("pulse mode while forced fixed frequency");

  property p_delay_closed;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(state == buck_seq_pkg::ST_DELAY) |-> (!bus_access_ok && !hs_gate)[*8];
  endproperty
  a_delay_closed: assert property (p_delay_closed)
    else $error("bus or switching open during enable delay");

  property p_limit;
    @(posedge clk_sys) disable iff (!reset_n) hs_s |=> !hs_gate && (ls_gate || !switching);
  endproperty
  a_limit: assert property (p_limit)
    else $error("high side on during current limit");

  property p_hiccup_quiet;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(state == buck_seq_pkg::ST_HICCUP) |=> !hs_gate && !ls_gate;
  endproperty
  a_hiccup_quiet: assert property (p_hiccup_quiet)
    else $error("switching during hiccup wait");

  property p_latched;
    @(posedge clk_sys) disable iff (!reset_n)
      state == buck_seq_pkg::ST_LATCHED && en_s && !ctrl_wr |=>
        state == buck_seq_pkg::ST_LATCHED;
  endproperty
  a_latched: assert property (p_latched)
    else $error("latched off left without unlatch event");

  property p_pin_off;
    @(posedge clk_sys) disable iff (!reset_n)
      !en_s |=> !bus_access_ok && !forced_fixed_frequency_mode && !hs_gate;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("state kept while enable low");

  property p_discharge;
    @(posedge clk_sys) disable iff (!reset_n)
      !en_s && discharge_enable ##1 !en_s && discharge_enable |-> discharge_on;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("no discharge in shutdown");

  property p_r2d_off;
    @(posedge clk_sys) disable iff (!reset_n) switching |-> !resistor_code_decoder_on;
  endproperty
  a_r2d_off: assert property (p_r2d_off)
    else $error("resistor current source left on");
endmodule

// ---- host_model.sv ----
// host side model: control bus writer and enable pin driver
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_sys,
  input  wire logic       bus_access_ok,
  output logic            enable_pin,
  output logic            ctrl_wr,
  output logic            wr_sw_enable,
  output logic            wr_forced_fixed_frequency_mode,
  output logic            wr_hiccup,
  output logic            wr_discharge,
  output logic            setpoint_wr,
  output logic [7:0]      setpoint_data,
  output logic            status_clear
);
  // idle bus at time zero
  initial begin
    {enable_pin, ctrl_wr, setpoint_wr, status_clear} = 4'h0;
    {wr_sw_enable, wr_forced_fixed_frequency_mode, wr_hiccup, wr_discharge} = 4'h0;
    setpoint_data = 8'h00;
  end
  task automatic set_enable(input logic v);
    @(negedge clk_sys);
    enable_pin = v;
  endtask
  // wait for access unless told to try anyway
  task automatic write(input logic [3:0] b, input logic spw, input logic [7:0] d,
                       input logic force_it);
    int n;
    n = 0;
    while (!force_it && bus_access_ok !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    {wr_sw_enable, wr_forced_fixed_frequency_mode, wr_hiccup, wr_discharge} = b;
    setpoint_data = d;
    ctrl_wr = !spw;
    setpoint_wr = spw;
    @(negedge clk_sys);
    {ctrl_wr, setpoint_wr} = 2'h0;
    // released data inverted so stale values never look valid
    {wr_sw_enable, wr_forced_fixed_frequency_mode, wr_hiccup, wr_discharge} = ~b;
    setpoint_data = ~d;
  endtask
  task automatic clear_status;
    @(negedge clk_sys);
    status_clear = 1'b1;
    @(negedge clk_sys);
    status_clear = 1'b0;
  endtask
endmodule

// ---- tb.sv ----
// testbench: reference model, host model and scenarios
`timescale 1ns/1ps
module tb;
  localparam int DLY = 1200;
  localparam int RMP = 512;
  localparam int HIC = 100;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       enable_pin, ctrl_wr, wr_sw_enable, wr_forced_fixed_frequency_mode, wr_hiccup, wr_discharge;
  logic       setpoint_wr, status_clear, vin_lockout, vin_near_vout, light_load;
  logic       hs_limit, ls_limit, thermal_warning_level, thermal_shutdown_level;
  logic       thermal_release, pwm_on_request, hs_gate, ls_gate, light_load_pulse_mode;
  logic       forced_fixed_frequency_mode, hiccup_enable, sw_enable, discharge_enable;
  logic       discharge_on, resistor_code_decoder_on, bus_access_ok, switching;
  logic       low_input_lockout, warning_flag;
  logic [7:0] setpoint_data, output_sense_pin, vout_ref, startup_code, setpoint;
  logic [3:0] setpoint_select_pin;
  logic [6:0] target_address;
  logic [3:0] m_regs = 4'hB;
  logic [15:0] lfsr = 16'hCCED;
  int         checks = 0;
  int         n_mismatch = 0;
  logic [6:0] addr_tab [16] = '{7'h47, 7'h40, 7'h4F, 7'h4E, 7'h4D, 7'h4C, 7'h4B, 7'h4A,
                                7'h49, 7'h48, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46};

  always #5 clk_sys = ~clk_sys;

  buck_mode_fault_sequencer #(.DELAY_CYC(DLY), .RAMP_CYC(RMP), .HICCUP_CYC(HIC))
    u_buck_mode_fault_sequencer (
    .clk_sys, .reset_n, .enable_pin, .vin_lockout, .vin_near_vout, .light_load,
    .hs_limit, .ls_limit, .thermal_warning_level, .thermal_shutdown_level,
    .thermal_release, .pwm_on_request, .output_sense_pin, .setpoint_select_pin,
    .ctrl_wr, .wr_sw_enable, .wr_forced_fixed_frequency_mode, .wr_hiccup, .wr_discharge, .setpoint_wr,
    .setpoint_data, .status_clear, .hs_gate, .ls_gate, .light_load_pulse_mode,
    .forced_fixed_frequency_mode, .hiccup_enable, .sw_enable, .discharge_enable,
    .discharge_on, .resistor_code_decoder_on, .bus_access_ok, .switching, .vout_ref,
    .startup_code, .target_address, .setpoint, .low_input_lockout, .warning_flag);

  host_model u_host_model (
    .clk_sys, .bus_access_ok, .enable_pin, .ctrl_wr, .wr_sw_enable, .wr_forced_fixed_frequency_mode,
    .wr_hiccup, .wr_discharge, .setpoint_wr, .setpoint_data, .status_clear);

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // level to code: 0.40 V plus 0.05 V steps, 12.5 mV lsb, factor 1
  function automatic logic [7:0] st_code(input int lvl);
    return 8'((400 + 50 * lvl) * 10 / 125);
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // control bits in order sw, forced_fixed_frequency_mode, hiccup, discharge
  task automatic regs;
    cmp("ctrl_bits", {4'h0, m_regs},
        {4'h0, sw_enable, forced_fixed_frequency_mode, hiccup_enable, discharge_enable});
  endtask
  task automatic wr(input logic [3:0] b);
    u_host_model.write(b, 1'b0, 8'h00, 1'b0);
    m_regs = b;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return switching;
      default: return resistor_code_decoder_on;
    endcase
  endfunction
  // bounded wait, so a stuck sequencer shows as a mismatch, not a hang
  task automatic wait_for(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      tick(1);
      n++;
    end
    cmp("wait_done", {7'h0, v}, {7'h0, pick(k)});
  endtask
  task automatic trips(input int n);
    repeat (n) begin
      hs_limit = 1'b1;
      tick(4);
      hs_limit = 1'b0;
      tick(4);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: sixteen start-ups of about 2k cycles dominate the run
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    final_report;
  end

  initial begin
    int n;
    logic [7:0] sense;
    logic [7:0] sp;
    logic [7:0] st;
    {vin_lockout, vin_near_vout, light_load, hs_limit, ls_limit} = 5'h00;
    {thermal_warning_level, thermal_shutdown_level, thermal_release, pwm_on_request} = 4'h0;
    output_sense_pin = 8'h00;
    setpoint_select_pin = 4'h0;
    tick(12);
    reset_n = 1'b1;
    tick(3);
    regs;
    cmp("gates_off", 8'h00, {6'h0, hs_gate, ls_gate});
    cmp("dis_low_en", 8'h01, {7'h0, discharge_on});
    for (int lvl = 0; lvl < 16; lvl++) begin
      lfsr = lfsr_next(lfsr);
      sense = {4'h0, lfsr[3:0]};
      output_sense_pin = sense;
      setpoint_select_pin = lvl[3:0];
      u_host_model.set_enable(1'b1);
      m_regs = 4'hB;
      wait_for(1, 1'b1, 20, n);
      cmp("dis_default", 8'h01, {7'h0, discharge_enable});
      u_host_model.write(4'hF, 1'b0, 8'h00, 1'b1);
      wait_for(1, 1'b0, 1100, n);
      cmp("startup_code", st_code(lvl), startup_code);
      cmp("address", {1'b0, addr_tab[lvl]}, {1'b0, target_address});
      cmp("bus_ok_delay", 8'h00, {7'h0, bus_access_ok});
      regs;
      wait_for(0, 1'b1, DLY, n);
      cmp("bus_ok", 8'h01, {7'h0, bus_access_ok});
      cmp("prebias", sense, vout_ref);
      tick(20);
      cmp("ramp_rate", 8'h01, {7'h0, vout_ref >= sense + 8'h09 && vout_ref <= sense + 8'h0B});
      sp = st_code(lvl);
      if (lvl == 5) begin
        lfsr = lfsr_next(lfsr);
        sp = 8'h40 + {3'h0, lfsr[4:0]};
        u_host_model.write(4'h0, 1'b1, sp, 1'b0);
      end
      tick(RMP + 300);
      cmp("setpoint", sp, setpoint);
      cmp("vout_final", sp, vout_ref);
      if (lvl < 15) begin
        wr(4'hE);
        u_host_model.set_enable(1'b0);
        tick(5);
        m_regs = 4'hA;
        regs;
        cmp("no_discharge", 8'h00, {7'h0, discharge_on});
      end
      $display("test startup level %0d done", lvl);
    end
    // light-load mode selection
    light_load = 1'b1;
    tick(6);
    cmp("pulse_mode", 8'h01, {7'h0, light_load_pulse_mode});
    vin_near_vout = 1'b1;
    tick(6);
    cmp("near_dropout", 8'h00, {7'h0, light_load_pulse_mode});
    vin_near_vout = 1'b0;
    wr(4'hF);
    tick(4);
    cmp("forced_mode", 8'h00, {7'h0, light_load_pulse_mode});
    regs;
    wr(4'hB);
    light_load = 1'b0;
    $display("test modes done");
    // overload: hiccup then latch
    trips(31);
    cmp("trip_31", 8'h01, {7'h0, switching});
    trips(1);
    wait_for(0, 1'b0, 10, n);
    wait_for(0, 1'b1, HIC + 50, n);
    cmp("hiccup_wait", 8'h01, {7'h0, n >= HIC - 10 && n <= HIC + 5});
    wr(4'h9);
    trips(32);
    tick(HIC * 3);
    cmp("latched", 8'h00, {7'h0, switching});
    wr(4'h9);
    wait_for(0, 1'b1, 20, n);
    $display("test overload done");
    // cycle-by-cycle gate override
    pwm_on_request = 1'b1;
    tick(5);
    cmp("hs_on", 8'h02, {6'h0, hs_gate, ls_gate});
    hs_limit = 1'b1;
    tick(5);
    cmp("limit", 8'h01, {6'h0, hs_gate, ls_gate});
    hs_limit = 1'b0;
    tick(5);
    cmp("hold_low", 8'h01, {6'h0, hs_gate, ls_gate});
    ls_limit = 1'b1;
    tick(5);
    cmp("release", 8'h02, {6'h0, hs_gate, ls_gate});
    ls_limit = 1'b0;
    // software enable restart without delay or resampling
    st = startup_code;
    wr(4'h1);
    tick(5);
    cmp("sw_off", 8'h01, {6'h0, switching, discharge_on});
    wr(4'h9);
    wait_for(0, 1'b1, 20, n);
    cmp("no_resample", st, startup_code);
    regs;
    $display("test gates and software enable done");
    // lockout and thermal faults
    vin_lockout = 1'b1;
    tick(5);
    cmp("lockout", 8'h03, {5'h0, switching, discharge_on, low_input_lockout});
    regs;
    vin_lockout = 1'b0;
    wait_for(0, 1'b1, 20, n);
    cmp("flag_sticky", 8'h01, {7'h0, low_input_lockout});
    u_host_model.clear_status;
    tick(2);
    cmp("flag_clear", 8'h00, {7'h0, low_input_lockout});
    thermal_warning_level = 1'b1;
    tick(5);
    cmp("warning", 8'h03, {6'h0, switching, warning_flag});
    thermal_shutdown_level = 1'b1;
    tick(5);
    cmp("tsd", 8'h01, {6'h0, switching, discharge_on});
    thermal_shutdown_level = 1'b0;
    tick(10);
    cmp("tsd_hold", 8'h00, {7'h0, switching});
    thermal_release = 1'b1;
    wait_for(0, 1'b1, 20, n);
    regs;
    $display("test faults done");
    // supply collapse mid-run
    wr(4'hC);
    reset_n = 1'b0;
    tick(2);
    m_regs = 4'hB;
    regs;
    cmp("flags", 8'h00, {6'h0, low_input_lockout, warning_flag});
    reset_n = 1'b1;
    $display("test reset done");
    final_report;
  end
endmodule
